//--- rtl/adcdm_chan.sv
// adc decimation, digital microphone and dc measurement: one channel
// assumes bit_stb marks one modulator period and bit_val is already synchronised
`timescale 1ns/1ps
module adcdm_chan
    import adcdm_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic        clk_en,
    input  wire logic        bit_stb,
    input  wire logic        bit_val,
    input  wire logic        enable,
    input  wire logic [7:0]  osr,
    input  wire logic        dc_en,
    input  wire logic        dc_iir,
    input  wire logic [4:0]  dc_len,
    input  wire logic        per_en,
    input  wire logic [4:0]  per_exp,
    output logic             word_stb,
    output logic [31:0]      word,
    output logic [23:0]      dc_val
);

    typedef struct packed {
        logic [7:0]         cnt;
        logic signed [8:0]  sum;
        logic               word_stb;
        logic [31:0]        word;
        logic signed [22:0] acc;
        logic [20:0]        acnt;
        logic signed [23:0] iir;
        logic [31:0]        pcnt;
        logic [23:0]        dc_val;
    } adcdm_chan_st_t;

    adcdm_chan_st_t r, n;

    logic signed [8:0]  step9;
    logic [4:0]         d;
    logic signed [8:0]  sum_new;
    logic signed [22:0] acc_new;
    logic signed [23:0] x;
    logic [20:0]        alen;
    logic [31:0]        pmask;

    // ==========================================================
    // next state
    always_comb begin
        n       = r;
        n.word_stb = 1'b0;
        step9   = bit_val ? 9'sh001 : 9'sh1ff;
        d       = (dc_len < DC_LEN_MIN) ? DC_LEN_MIN :
                  ((dc_len > DC_LEN_MAX) ? DC_LEN_MAX : dc_len);
        sum_new = r.sum + step9;
        acc_new = r.acc + 23'(step9);
        x       = bit_val ? $signed(DC_ONE) : -$signed(DC_ONE);
        alen    = 21'(~(32'hffffffff << d));
        pmask   = ~(32'hffffffff << per_exp);
        if (bit_stb && enable) begin
            // decimation factor taken from the oversampling ratio
            if (r.cnt >= 8'(osr - 8'h01)) begin
                n.word     = {sum_new, 23'h000000};
                n.word_stb = 1'b1;
                n.cnt      = 8'h00;
                n.sum      = 9'sh000;
            end else begin
                n.cnt = r.cnt + 8'h01;
                n.sum = sum_new;
            end
        end
        if (!enable) begin
            n.cnt = 8'h00;
            n.sum = 9'sh000;
        end
        if (bit_stb && dc_en) begin
            if (!dc_iir) begin
                // averaging filter over 2^d modulator periods
                if (r.acnt == alen) begin
                    n.dc_val = 24'(acc_new) <<< (DC_FRAC - int'(d)); // 2.22 result
                    n.acc    = 23'sh000000;
                    n.acnt   = 21'h000000;
                end else begin
                    n.acc  = acc_new;
                    n.acnt = r.acnt + 21'h000001;
                end
            end else begin
                // first-order iir, bandwidth set by d
                n.iir    = r.iir + ((x - r.iir) >>> d);
                n.dc_val = n.iir;
            end
            // periodic filter reset every 2^R modulator clocks
            if (per_en && (r.pcnt == pmask)) begin
                n.pcnt = 32'h00000000;
                n.acc  = 23'sh000000;
                n.acnt = 21'h000000;
                n.iir  = 24'sh000000;
            end else begin
                n.pcnt = r.pcnt + 32'h00000001;
            end
        end
        if (!dc_en) begin
            n.acc  = 23'sh000000;
            n.acnt = 21'h000000;
            n.iir  = 24'sh000000;
            n.pcnt = 32'h00000000;
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '0;
        end else if (clk_en) begin
            r <= n;
        end
    end

    assign word_stb = r.word_stb;
    assign word     = r.word;
    assign dc_val   = r.dc_val;

endmodule : adcdm_chan

//--- rtl/adcdm_pad.sv
`timescale 1ns/1ps

//--- rtl/adcdm_pkg.sv
// adc decimation, digital microphone and dc measurement: shared constants and types
// assumes a 32-bit apb slave whose register index is the byte address divided by four
package adcdm_pkg;

    // ==========================================================
    // register indices (byte address = 4 * index)
    localparam logic [7:0] IDX_OSR        = 8'h14;
    localparam logic [7:0] IDX_WLEN       = 8'h1b;
    localparam logic [7:0] IDX_GPIO_CTL   = 8'h33;
    localparam logic [7:0] IDX_MISO_CTL   = 8'h37;
    localparam logic [7:0] IDX_PRESET     = 8'h3d;
    localparam logic [7:0] IDX_DMIC       = 8'h51;
    localparam logic [7:0] IDX_PHASE      = 8'h55;
    localparam logic [7:0] IDX_DC_CFG     = 8'h66;
    localparam logic [7:0] IDX_DC_LATCH   = 8'h67;
    localparam logic [7:0] IDX_DC_LEFT    = 8'h68;
    localparam logic [7:0] IDX_DC_RIGHT   = 8'h6b;

    // ==========================================================
    // field positions
    localparam int PH_LEFT_BIT    = 7;
    localparam int DC_EN_L_BIT    = 7;
    localparam int DC_EN_R_BIT    = 6;
    localparam int DC_IIR_BIT     = 5;
    localparam int DC_LATCH_BIT   = 6;
    localparam int DC_PER_EN_BIT  = 5;
    localparam int DMIC_EN_L_BIT  = 1;
    localparam int DMIC_EN_R_BIT  = 0;

    // ==========================================================
    // reset values
    localparam logic [7:0] RST_OSR    = 8'h40;
    localparam logic [7:0] RST_PRESET = 8'h01;
    localparam logic [7:0] RST_WLEN   = 8'h00;
    localparam logic [7:0] RST_ZERO   = 8'h00;

    // ==========================================================
    // decimation variants and preset mapping
    typedef enum logic [1:0] {
        VAR_A = 2'b00,
        VAR_B = 2'b01,
        VAR_C = 2'b10
    } adcdm_var_t;

    localparam logic [4:0] PRESET_B_FIRST = 5'h07;
    localparam logic [4:0] PRESET_C_FIRST = 5'h0d;
    localparam logic [7:0] OSR_VAR_B      = 8'h40;
    localparam logic [7:0] OSR_VAR_C      = 8'h20;
    localparam logic [1:0] KF_SHIFT_A     = 2'h2;
    localparam logic [1:0] KF_SHIFT_B     = 2'h1;
    localparam logic [1:0] KF_SHIFT_C     = 2'h0;

    // ==========================================================
    // pin routing codes and microphone data sources
    localparam logic [3:0] ROUTE_GPIO_MODCLK = 4'ha;
    localparam logic [3:0] ROUTE_MISO_MODCLK = 4'h7;
    localparam logic [1:0] SRC_GPIO          = 2'h0;
    localparam logic [1:0] SRC_DIN           = 2'h1;
    localparam logic [1:0] SRC_SCLK          = 2'h2;

    // ==========================================================
    // dc measurement limits and scaling
    localparam logic [4:0]  DC_LEN_MIN  = 5'h01;
    localparam logic [4:0]  DC_LEN_MAX  = 5'h14;
    localparam logic [23:0] DC_ONE      = 24'h400000;
    localparam int          DC_FRAC     = 22;

    // ==========================================================
    // output carrier: one pair of words per output sample
    typedef struct packed {
        logic        valid;
        logic [31:0] left;
        logic [31:0] right;
    } adcdm_word_t;

endpackage : adcdm_pkg

//--- rtl/adcdm_top.sv
// adc decimation, digital microphone and dc measurement: top with apb registers
// assumes modulator_clock and microphone pins are asynchronous to ref_clk
//
// Overview of operation
// - variant B decimates by oversampling ratio 64, rates up to 96 kHz.
// - variant C decimates by ratio 32 for 192 ksps, passband near 0.11 fs.
// - variant is derived from the processing block preset, never chosen directly.
// - 32-bit words go to the serial interface once per output sample.
// - each output sample carries one left word and one right word.
// - words are rounded to the configured interface word length.
// - modulator clock routes to the gpio pin or the miso pin by register.
// - left bit sampled on rising modulator edge, right on falling edge.
// - microphone capture enabled for left, right or both channels.
// - analog front end powered down; oversampling ratio sets decimation factor.
// - phase byte: fine right in 4:0, coarse right 6:5, left in 7.
// - right delayed fine plus coarse times ratio times factor; left by bit 7.
// - coarse factor is 0.25, 0.5 or 1 for variants A, B, C.
// - dc measurement enabled per channel; only on channels not recording (not enforced: dc_en ignores the microphone enables).
// - each dc result is 24 bits in 2.22 format.
// - left result read at 0x68, right result at 0x6b.
// - setting the latch bit captures results; software clears it after reading.
// - averaging filter of length 1 to 20 when iir select is zero.
// - first-order iir with bandwidth set by the 5-bit setting when selected.
// - periodic filter reset every 2^R modulator clocks when enabled.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
module adcdm_top
    import adcdm_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        modulator_clock,
    input  wire logic        gpio_in,
    input  wire logic        din_in,
    input  wire logic        sclk_in,
    output logic             gpio_out,
    output logic             gpio_oe_n,
    output logic             miso_out,
    output logic             miso_oe_n,
    output logic             afe_pd_left,
    output logic             afe_pd_right,
    output adcdm_word_t      sample_out
);

    typedef struct packed {
        logic               pready;
        logic               pslverr;
        logic [31:0]        prdata;
        logic [7:0]         osr;
        logic [7:0]         wlen;
        logic [7:0]         gpio_ctl;
        logic [7:0]         miso_ctl;
        logic [7:0]         preset;
        logic [7:0]         dmic;
        logic [7:0]         phase;
        logic [7:0]         dc_cfg;
        logic [7:0]         dc_latch;
        logic [23:0]        hold_l;
        logic [23:0]        hold_r;
        logic               mclk_s1;
        logic               mclk_s2;
        logic               mclk_s3;
        logic [2:0]         pin_s1;
        logic [2:0]         pin_s2;
        logic               ldly;
        logic [126:0]       rdly;
        logic               lbit_stb;
        logic               lbit;
        logic               rbit_stb;
        logic               rbit;
        logic [31:0]        lword;
        logic               gpio_out;
        logic               gpio_oe_n;
        logic               miso_out;
        logic               miso_oe_n;
        logic               afe_pd_l;
        logic               afe_pd_r;
        adcdm_word_t        out;
    } adcdm_top_st_t;

    adcdm_top_st_t r, n;

    logic        l_wstb;
    logic        r_wstb;
    logic [31:0] l_word;
    logic [31:0] r_word;
    logic [23:0] l_dc;
    logic [23:0] r_dc;
    adcdm_var_t  variant;
    logic [7:0]  osr_eff;
    logic [1:0]  kf_shift;
    logic [6:0]  rdelay;
    logic [7:0]  coarse_step;
    logic [7:0]  idx;
    logic        hit;
    logic        mrise;
    logic        mfall;
    logic        mic_bit;
    logic        en_l;
    logic        en_r;
    logic        pair_done;

    // ==========================================================
    // rounding to the interface word length
    function automatic logic [31:0] round_word(input logic [31:0] w, input logic [1:0] wl);
        logic [4:0]  s;
        logic [32:0] t;
        logic [31:0] m;
        s = (wl == 2'h0) ? 5'h10 : ((wl == 2'h1) ? 5'h0c : ((wl == 2'h2) ? 5'h08 : 5'h00));
        m = 32'hffffffff << s;
        if (s == 5'h00) begin
            t = {w[31], w};
        end else begin
            t = {w[31], w} + (33'h000000001 << (s - 5'h01));
        end
        if (!w[31] && t[31]) begin
            round_word = 32'h7fffffff & m;
        end else begin
            round_word = t[31:0] & m;
        end
    endfunction : round_word

    // ==========================================================
    // variant and delay derivation
    always_comb begin
        // variant follows the preset only
        if (r.preset[4:0] >= PRESET_C_FIRST) begin
            variant = VAR_C;
        end else if (r.preset[4:0] >= PRESET_B_FIRST) begin
            variant = VAR_B;
        end else begin
            variant = VAR_A;
        end
        case (variant)
            VAR_B: begin
                osr_eff  = OSR_VAR_B;
                kf_shift = KF_SHIFT_B;
            end
            VAR_C: begin
                osr_eff  = OSR_VAR_C;
                kf_shift = KF_SHIFT_C;
            end
            default: begin
                osr_eff  = r.osr;
                kf_shift = KF_SHIFT_A;
            end
        endcase
        // fine + coarse * ratio * factor modulator periods
        coarse_step = osr_eff >> kf_shift;
        rdelay      = 7'(r.phase[4:0] + 8'(r.phase[6:5] * coarse_step));
    end

    // ==========================================================
    // channel filters
    adcdm_chan u_left (
        .ref_clk  (ref_clk),
        .arst_n   (arst_n),
        .clk_en   (clk_en),
        .bit_stb  (r.lbit_stb),
        .bit_val  (r.lbit),
        .enable   (en_l),
        .osr      (osr_eff),
        .dc_en    (r.dc_cfg[DC_EN_L_BIT]),
        .dc_iir   (r.dc_cfg[DC_IIR_BIT]),
        .dc_len   (r.dc_cfg[4:0]),
        .per_en   (r.dc_latch[DC_PER_EN_BIT]),
        .per_exp  (r.dc_latch[4:0]),
        .word_stb (l_wstb),
        .word     (l_word),
        .dc_val   (l_dc)
    );

    adcdm_chan u_right (
        .ref_clk  (ref_clk),
        .arst_n   (arst_n),
        .clk_en   (clk_en),
        .bit_stb  (r.rbit_stb),
        .bit_val  (r.rbit),
        .enable   (en_r),
        .osr      (osr_eff),
        .dc_en    (r.dc_cfg[DC_EN_R_BIT]),
        .dc_iir   (r.dc_cfg[DC_IIR_BIT]),
        .dc_len   (r.dc_cfg[4:0]),
        .per_en   (r.dc_latch[DC_PER_EN_BIT]),
        .per_exp  (r.dc_latch[4:0]),
        .word_stb (r_wstb),
        .word     (r_word),
        .dc_val   (r_dc)
    );

    // ==========================================================
    // next state
    always_comb begin
        n = r;
        en_l  = r.dmic[DMIC_EN_L_BIT];
        en_r  = r.dmic[DMIC_EN_R_BIT];
        idx   = paddr[9:2];
        // microphone pins and modulator clock through two flops
        n.mclk_s1 = modulator_clock;
        n.mclk_s2 = r.mclk_s1;
        n.mclk_s3 = r.mclk_s2;
        n.pin_s1  = {sclk_in, din_in, gpio_in};
        n.pin_s2  = r.pin_s1;
        mrise = r.mclk_s2 && !r.mclk_s3;
        mfall = !r.mclk_s2 && r.mclk_s3;
        case (r.dmic[3:2])
            SRC_DIN:  mic_bit = r.pin_s2[1];
            SRC_SCLK: mic_bit = r.pin_s2[2];
            default:  mic_bit = r.pin_s2[0];
        endcase

        // left on rising edge, right on falling edge
        n.lbit_stb = mrise;
        n.rbit_stb = mfall;
        if (mrise) begin
            n.lbit = r.phase[PH_LEFT_BIT] ? r.ldly : mic_bit;
            n.ldly = mic_bit;
        end
        if (mfall) begin
            n.rbit = (rdelay == 7'h00) ? mic_bit : r.rdly[rdelay - 7'h01];
            n.rdly = {r.rdly[125:0], mic_bit};
        end

        // one left and one right word per output sample
        pair_done = en_r ? r_wstb : l_wstb;
        if (l_wstb) begin
            n.lword = l_word;
        end
        n.out.valid = 1'b0;
        if (pair_done) begin
            n.out.valid = 1'b1;
            n.out.left  = en_l ? round_word(l_wstb ? l_word : r.lword, r.wlen[1:0]) : '0;
            n.out.right = en_r ? round_word(r_word, r.wlen[1:0]) : '0;
        end

        // modulator clock routing
        n.gpio_oe_n = (r.gpio_ctl[5:2] != ROUTE_GPIO_MODCLK);
        n.gpio_out  = !n.gpio_oe_n && r.mclk_s2;
        n.miso_oe_n = (r.miso_ctl[4:1] != ROUTE_MISO_MODCLK);
        n.miso_out  = !n.miso_oe_n && r.mclk_s2;
        n.afe_pd_l  = en_l;
        n.afe_pd_r  = en_r;

        // apb slave: answer in the first access cycle
        n.pready  = psel && !penable;
        n.pslverr = 1'b0;
        hit = 1'b1;
        case (idx)
            IDX_OSR:      n.prdata = {24'h000000, r.osr};
            IDX_WLEN:     n.prdata = {24'h000000, r.wlen};
            IDX_GPIO_CTL: n.prdata = {24'h000000, r.gpio_ctl};
            IDX_MISO_CTL: n.prdata = {24'h000000, r.miso_ctl};
            IDX_PRESET:   n.prdata = {24'h000000, r.preset};
            IDX_DMIC:     n.prdata = {24'h000000, r.dmic};
            IDX_PHASE:    n.prdata = {24'h000000, r.phase};
            IDX_DC_CFG:   n.prdata = {24'h000000, r.dc_cfg};
            IDX_DC_LATCH: n.prdata = {24'h000000, r.dc_latch};
            IDX_DC_LEFT:  n.prdata = {8'h00, r.hold_l};
            IDX_DC_RIGHT: n.prdata = {8'h00, r.hold_r};
            default: begin
                n.prdata = 32'h00000000;
                hit      = 1'b0;
            end
        endcase
        if (paddr[1:0] != 2'h0 || paddr[11:10] != 2'h0) begin
            hit = 1'b0;
        end
        if (psel && !penable) begin
            n.pslverr = !hit;
            if (!hit || pwrite) begin
                n.prdata = 32'h00000000;
            end
        end else begin
            n.prdata = r.prdata;
        end
        if (psel && penable && r.pready && pwrite && !r.pslverr) begin
            case (idx)
                IDX_OSR:      n.osr      = pwdata[7:0];
                IDX_WLEN:     n.wlen     = pwdata[7:0];
                IDX_GPIO_CTL: n.gpio_ctl = pwdata[7:0];
                IDX_MISO_CTL: n.miso_ctl = pwdata[7:0];
                IDX_PRESET:   n.preset   = pwdata[7:0];
                IDX_DMIC:     n.dmic     = pwdata[7:0];
                IDX_PHASE:    n.phase    = pwdata[7:0];
                IDX_DC_CFG:   n.dc_cfg   = pwdata[7:0];
                IDX_DC_LATCH: begin
                    n.dc_latch = pwdata[7:0];
                    // capture on latch request, hold while set
                    if (pwdata[DC_LATCH_BIT] && !r.dc_latch[DC_LATCH_BIT]) begin
                        n.hold_l = l_dc;
                        n.hold_r = r_dc;
                    end
                end
                default: n.osr = r.osr;
            endcase
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            r           <= '0;
            r.osr       <= RST_OSR;
            r.preset    <= RST_PRESET;
            r.wlen      <= RST_WLEN;
            r.gpio_oe_n <= 1'b1;
            r.miso_oe_n <= 1'b1;
        end else if (clk_en) begin
            r <= n;
        end
    end

    // ==========================================================
    // outputs
    assign prdata       = r.prdata;
    assign pready       = r.pready;
    assign pslverr      = r.pslverr;
    assign gpio_out     = r.gpio_out;
    assign gpio_oe_n    = r.gpio_oe_n;
    assign miso_out     = r.miso_out;
    assign miso_oe_n    = r.miso_oe_n;
    assign afe_pd_left  = r.afe_pd_l;
    assign afe_pd_right = r.afe_pd_r;
    assign sample_out   = r.out;

endmodule : adcdm_top

//--- verif/adcdm_mic.sv
// digital microphone model, one bit per modulator clock edge
// assumes the device samples within 300 ns of each edge
`timescale 1ns/1ps
module adcdm_mic (
    input  wire logic mclk,
    input  wire logic lbit,
    input  wire logic rbit,
    output logic      dat
);
    initial dat = 1'b0;
    // same clock as the routed pin; data steady across each edge
    always @(posedge mclk) #350 dat = rbit;
    always @(negedge mclk) #350 dat = lbit;
endmodule : adcdm_mic

//--- verif/adcdm_monitor.sv
// assertions on the top ports of the microphone and dc block
// assumes clk_en held high by the bench
`timescale 1ns/1ps
module adcdm_monitor
    import adcdm_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        arst_n,
    input wire logic        clk_en,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    input wire logic        modulator_clock,
    input wire logic        gpio_out,
    input wire logic        gpio_oe_n,
    input wire adcdm_word_t sample_out
);
    // ====
    // sequences
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    sequence s_setup;
        psel && !penable && clk_en;
    endsequence
    sequence s_quiet;
        !sample_out.valid [*8];
    endsequence
    // ====
    // checks
    a_ready_setup: assert property (s_setup |=> pready)
        else $error("no ready after setup");
    a_ready_once: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("read data moved");
    a_valid_pulse: assert property (sample_out.valid |=> s_quiet)
        else $error("sample pulses too close");
    a_words_hold: assert property (!sample_out.valid
        |-> $stable({sample_out.left, sample_out.right}))
        else $error("words moved without valid");
    a_gpio_clock: assert property (!gpio_oe_n && $rose(modulator_clock)
        |-> ##[1:5] gpio_out)
        else $error("gpio not following modulator clock");
endmodule : adcdm_monitor

bind adcdm_top adcdm_monitor u_mon (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .modulator_clock(modulator_clock), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
    .sample_out(sample_out));

//--- verif/test_adc_decimation_dmic_dc_measure.sv
// self-checking bench for the microphone and dc measurement top
// assumes a wait-free apb slave and a free running modulator clock
`timescale 1ns/1ps
module test_adc_decimation_dmic_dc_measure;
    import adcdm_pkg::*;
    logic        ref_clk, arst_n, clk_en, psel, penable, pwrite, mclk, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, gpio_in, sclk_in, din_in, lbit, rbit;
    logic        gpio_out, gpio_oe_n, miso_out, miso_oe_n, afe_pd_left, afe_pd_right;
    adcdm_word_t sample_out;
    int          num_errors, n_compared;

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial begin
        mclk = 1'b0;
        #13;
        forever #400 mclk = ~mclk;
    end
    always @(posedge ref_clk) begin
        gpio_in <= 1'($urandom);
        sclk_in <= 1'($urandom);
    end

    adcdm_top DUT (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .modulator_clock(mclk), .gpio_in(gpio_in),
        .din_in(din_in), .sclk_in(sclk_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
        .miso_out(miso_out), .miso_oe_n(miso_oe_n), .afe_pd_left(afe_pd_left),
        .afe_pd_right(afe_pd_right), .sample_out(sample_out));
    adcdm_mic u_mic (.mclk(mclk), .lbit(lbit), .rbit(rbit), .dat(din_in));

    // ====
    // tasks
    task automatic conclude;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
            if (i == 15) begin
                num_errors++;
                conclude();
            end
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_valid;
        for (int i = 0; i < 2000; i++) begin
            @(posedge ref_clk);
            if (sample_out.valid === 1'b1) return;
        end
        num_errors++;
        conclude();
    endtask : wait_valid

    function automatic logic [31:0] exp_word(input logic en, input logic b, input int osr);
        logic [31:0] v;
        v = 32'(osr) << 23;
        return !en ? 32'h0 : (b ? v : 32'h0 - v);
    endfunction : exp_word

    // ====
    // main sequence
    initial begin
        logic [7:0] regs [3] = '{IDX_PHASE, IDX_DC_CFG, IDX_DC_LATCH};
        logic [4:0] pre [5] = '{5'h01, 5'h07, 5'h0d, 5'h0d, 5'h07};
        logic [1:0] en [5] = '{2'h3, 2'h2, 2'h1, 2'h3, 2'h3};
        int         osr [5] = '{64, 64, 32, 32, 64};
        logic [7:0] ph;
        {psel, penable, pwrite, paddr, pwdata, arst_n, lbit, rbit} = '0;
        clk_en = 1'b1;
        num_errors = 0;
        n_compared = 0;
        void'($urandom(32'h0342));
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, regs[i], 32'h0);
            chk(rd, 32'h0);
        end
        ph = 8'($urandom);
        apb(1'b1, IDX_PHASE, {24'h0, ph});
        apb(1'b0, IDX_PHASE, 32'h0);
        chk(rd, {24'h0, ph});
        apb(1'b0, 8'h70, 32'h0);
        chk({31'h0, er}, 32'h1);
        apb(1'b1, IDX_DC_LEFT, 32'hffffff);
        chk({31'h0, er}, 32'h0);
        apb(1'b0, IDX_DC_LEFT, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, IDX_PHASE, 32'h0);
        $display("register test done");
        apb(1'b1, IDX_MISO_CTL, 32'h0e);
        apb(1'b1, IDX_GPIO_CTL, 32'h28);
        repeat (2) @(posedge ref_clk);
        chk({30'h0, gpio_oe_n, miso_oe_n}, 32'h0);
        for (int c = 0; c < 5; c++) begin
            lbit <= 1'($urandom);
            rbit <= 1'($urandom);
            apb(1'b1, IDX_PRESET, {27'h0, pre[c]});
            apb(1'b1, IDX_DMIC, {28'h0, SRC_DIN, en[c]});
            repeat (3) wait_valid();
            chk(sample_out.left, exp_word(en[c][1], lbit, osr[c]));
            chk(sample_out.right, exp_word(en[c][0], rbit, osr[c]));
            chk({30'h0, afe_pd_left, afe_pd_right}, {30'h0, en[c]});
        end
        $display("stream test done");
        lbit <= 1'b1;
        rbit <= 1'b0;
        apb(1'b1, IDX_DC_CFG, 32'hc1);
        repeat (3) wait_valid();
        apb(1'b1, IDX_DC_LATCH, 32'h40);
        apb(1'b0, IDX_DC_LEFT, 32'h0);
        chk(rd, {8'h0, DC_ONE});
        apb(1'b0, IDX_DC_RIGHT, 32'h0);
        chk(rd, {8'h0, 24'h0 - DC_ONE});
        lbit <= 1'b0;
        repeat (3) wait_valid();
        apb(1'b0, IDX_DC_LEFT, 32'h0);
        chk(rd, {8'h0, DC_ONE});
        apb(1'b1, IDX_DC_LATCH, 32'h0);
        apb(1'b1, IDX_DC_LATCH, 32'h40);
        apb(1'b0, IDX_DC_LEFT, 32'h0);
        chk(rd, {8'h0, 24'h0 - DC_ONE});
        $display("dc test done");
        conclude();
    end
endmodule : test_adc_decimation_dmic_dc_measure
